// ---- design/rps_map.svh ----
// register map, field positions and timing constants of the packet sequencer
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RPS_A_GO_TX     12'h000
`define RPS_A_GO_RX     12'h004
`define RPS_A_START     12'h008
`define RPS_A_STOP      12'h00C
`define RPS_A_DIS       12'h010
`define RPS_A_SS_GO     12'h014
`define RPS_A_BC_GO     12'h01C
`define RPS_A_BC_HALT   12'h020
`define RPS_A_EV_READY  12'h100
`define RPS_A_EV_ADDR   12'h104
`define RPS_A_EV_END    12'h10C
`define RPS_A_EV_DISD   12'h110
`define RPS_A_EV_HIT    12'h114
`define RPS_A_EV_MISS   12'h118
`define RPS_A_EV_SSD    12'h11C
`define RPS_A_EV_BCHIT  12'h128
`define RPS_A_LINKS     12'h200
`define RPS_A_FPTR      12'h504
`define RPS_A_MODE      12'h510
`define RPS_A_PKT0      12'h514
`define RPS_A_PKT1      12'h518
`define RPS_A_GAP       12'h544
`define RPS_A_SSV       12'h548
`define RPS_A_STATE     12'h550
`define RPS_A_BCT       12'h560
`define RPS_A_MLOW      12'h600
`define RPS_A_MHIGH     12'h620
`define RPS_A_MCFG      12'h640
// ----------------------------------------
// field positions
// ----------------------------------------
`define RPS_L_RDY_GO    0
`define RPS_L_END_DIS   1
`define RPS_L_DIS_TX    2
`define RPS_L_DIS_RX    3
`define RPS_L_ADR_BC    6
`define RPS_P0_LF_LSB   0
`define RPS_P0_H0       8
`define RPS_P0_H1_LSB   16
`define RPS_P0_FW       4
`define RPS_P1_LIM_LSB  0
`define RPS_P1_TAIL_LSB 8
`define RPS_P1_BIG      24
`define RPS_MC_KIND_LSB 8
`define RPS_KIND_BIT    6
`define RPS_ADDR_BITS   12'h030
// ----------------------------------------
// timing
// ----------------------------------------
`define RPS_CLK_MHZ     100
`define RPS_RAMP_US     40
`define RPS_DIS_US      2
`define RPS_SAMPLE_NS   250
`define RPS_FILT_K      2
`endif

// ---- design/rps_pkg.sv ----
// types shared by the packet sequencer
package rps_pkg;
  typedef enum logic [3:0] {
    RPS_OFF     = 4'h0,
    RPS_RX_RU   = 4'h1,
    RPS_RX_WAIT = 4'h2,
    RPS_RX      = 4'h3,
    RPS_RX_DIS  = 4'h4,
    RPS_TX_RU   = 4'h9,
    RPS_TX_WAIT = 4'hA,
    RPS_TX      = 4'hB,
    RPS_TX_DIS  = 4'hC
  } rps_state_e;

  // from the air-side front end, one-cycle pulses, and bit_val, the data level read with bit_vld
  typedef struct packed {
    logic preamble;
    logic addr_ok;
    logic bit_vld;
    logic bit_val;
    logic tx_done;
  } rps_air_s;

  // byte write request toward RAM
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [7:0]  data;
  } rps_dma_s;
endpackage

// ---- design/rps_sequencer.sv ----
// radio packet sequencer: states, field mover, address match, bit counter
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rps_map.svh"
module rps_sequencer import rps_pkg::*; #(
  parameter int N_ENTRY = 8,
  parameter int FILT_K  = `RPS_FILT_K
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // air side
  input  wire rps_air_s    air_in,
  input  wire logic [6:0]  strength_raw,
  output logic             phy_rx_on,
  output logic             phy_tx_on,
  output logic      [3:0]  phy_mode,
  output logic             tx_air_go,
  // ram writes
  output rps_dma_s         dma_out,
  input  wire logic        dma_ack
);
  if (N_ENTRY < 1 || N_ENTRY > 8) begin
    $error("N_ENTRY must lie in 1..8");
  end
  if (FILT_K < 1 || FILT_K > 4) begin
    $error("FILT_K must lie in 1..4");
  end

  localparam logic [15:0] RAMP_CYC = 16'(`RPS_RAMP_US * `RPS_CLK_MHZ - 1);
  localparam logic [15:0] DIS_CYC  = 16'(`RPS_DIS_US * `RPS_CLK_MHZ - 1);
  localparam logic [15:0] SS_CYC   = 16'((`RPS_SAMPLE_NS * `RPS_CLK_MHZ + 999) / 1000);
  localparam logic [6:0]  US_LAST  = 7'(`RPS_CLK_MHZ - 1);
  localparam logic [11:0] EV_A [8] = '{`RPS_A_EV_READY, `RPS_A_EV_ADDR, `RPS_A_EV_END,
    `RPS_A_EV_DISD, `RPS_A_EV_HIT, `RPS_A_EV_MISS, `RPS_A_EV_SSD, `RPS_A_EV_BCHIT};

  rps_state_e  state, next_state;
  logic [7:0]  links, ev, ev_set, ev_clr, ev_sel;
  logic [31:0] fptr, fptr_act, pkt0, pkt1, rd_data;
  logic [3:0]  mode;
  logic [9:0]  gap, gap_us;
  logic [15:0] bct, bc_cnt, tmr, ss_tmr;
  logic [15:0] mcfg;
  logic [31:0] mlow  [N_ENTRY];
  logic [15:0] mhigh [N_ENTRY];
  logic [6:0]  pre, ss_val;
  logic        rd_ok, bc_run, rx_act, pre_seen, tx_pend, kind;
  logic [8:0]  filt, woff;
  logic [1:0]  fld;
  logic [11:0] fbits, fsz;
  logic [2:0]  bcnt;
  logic [7:0]  sh, len_val;
  logic [47:0] pa;
  logic [N_ENTRY-1:0] ent_hit;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire wr       = psel & penable & pwrite & pready;
  wire t_go_tx  = wr & (paddr == `RPS_A_GO_TX) & pwdata[0];
  wire t_go_rx  = wr & (paddr == `RPS_A_GO_RX) & pwdata[0];
  wire t_start  = wr & (paddr == `RPS_A_START) & pwdata[0];
  wire t_stop   = wr & (paddr == `RPS_A_STOP) & pwdata[0];
  wire t_dis    = wr & (paddr == `RPS_A_DIS) & pwdata[0];
  wire t_ss_go  = wr & (paddr == `RPS_A_SS_GO) & pwdata[0];
  wire t_bc_go  = wr & (paddr == `RPS_A_BC_GO) & pwdata[0];
  wire t_bc_hlt = wr & (paddr == `RPS_A_BC_HALT) & pwdata[0];
  wire ml_sel   = ({paddr[11:5], 5'h00} == `RPS_A_MLOW) & (32'(paddr[4:2]) < N_ENTRY);
  wire mh_sel   = ({paddr[11:5], 5'h00} == `RPS_A_MHIGH) & (32'(paddr[4:2]) < N_ENTRY);
  wire [2:0] idx = paddr[4:2];

  for (genvar i = 0; i < 8; i++) begin : g_ev
    assign ev_sel[i] = (paddr == EV_A[i]);
    assign ev_clr[i] = wr & ev_sel[i] & ~pwdata[0];
  end

  // ----------------------------------------
  // tasks with shortcuts folded in
  // ----------------------------------------
  wire in_ru   = (state == RPS_RX_RU) | (state == RPS_TX_RU);
  wire in_dis  = (state == RPS_RX_DIS) | (state == RPS_TX_DIS);
  wire tmr_z   = (tmr == 16'h0000);
  wire e_ready = in_ru & tmr_z;
  wire e_disd  = in_dis & tmr_z;
  wire pkt_done;
  wire e_end   = ((state == RPS_RX) & pkt_done) |
                 ((state == RPS_TX) & air_in.tx_done);
  wire go_start = t_start | (links[`RPS_L_RDY_GO] & e_ready);
  wire go_dis   = t_dis | (links[`RPS_L_END_DIS] & e_end);
  wire go_tx    = t_go_tx | (links[`RPS_L_DIS_TX] & e_disd);
  wire go_rx    = t_go_rx | (links[`RPS_L_DIS_RX] & e_disd);
  wire e_addr   = (state == RPS_RX) & pre_seen & ~rx_act & air_in.addr_ok;

  // ----------------------------------------
  // radio state sequence
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (go_dis && state != RPS_OFF && !in_dis) begin
      next_state = state[3] ? RPS_TX_DIS : RPS_RX_DIS;
    end else begin
      case (state)
        RPS_OFF: begin
          if (go_rx) begin
            next_state = RPS_RX_RU;
          end else if (go_tx) begin
            next_state = RPS_TX_RU;
          end
        end
        RPS_RX_RU, RPS_TX_RU: begin
          if (tmr_z) begin
            next_state = go_start ? rps_state_e'(state + 4'h2) : rps_state_e'(state + 4'h1);
          end
        end
        // start taken only once ramp-up has completed
        RPS_RX_WAIT, RPS_TX_WAIT: begin
          if (go_start) begin
            next_state = rps_state_e'(state + 4'h1);
          end
        end
        RPS_RX, RPS_TX: begin
          if (e_end || t_stop) begin
            next_state = rps_state_e'(state - 4'h1);
          end
        end
        RPS_RX_DIS, RPS_TX_DIS: begin
          if (tmr_z) begin
            next_state = go_rx ? RPS_RX_RU : (go_tx ? RPS_TX_RU : RPS_OFF);
          end
        end
        default: next_state = RPS_OFF;
      endcase
    end
  end

  wire ld_tmr = (next_state != state) &
    ((next_state == RPS_RX_RU) | (next_state == RPS_TX_RU) |
     (next_state == RPS_RX_DIS) | (next_state == RPS_TX_DIS));
  wire is_dis_n = (next_state == RPS_RX_DIS) | (next_state == RPS_TX_DIS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= RPS_OFF;
      tmr       <= 16'h0000;
      phy_rx_on <= 1'b0;
      phy_tx_on <= 1'b0;
    end else begin
      state     <= next_state;
      tmr       <= ld_tmr ? (is_dis_n ? DIS_CYC : RAMP_CYC) : (tmr_z ? tmr : tmr - 16'h0001);
      phy_rx_on <= (next_state == RPS_RX_RU) | (next_state == RPS_RX_WAIT) | (next_state == RPS_RX);
      phy_tx_on <= (next_state == RPS_TX_RU) | (next_state == RPS_TX_WAIT) | (next_state == RPS_TX);
    end
  end

  // mode and pointer are shadowed; the live copies change only on their task
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_mode <= 4'h0;
      fptr_act <= 32'h0000_0000;
    end else begin
      // every ramp-up start is an enable task, shortcut-driven ones included
      if (ld_tmr && !is_dis_n) phy_mode <= mode;
      if (go_start) fptr_act <= fptr;
    end
  end

  // ----------------------------------------
  // turnaround gap, counted in whole microseconds from END
  // ----------------------------------------
  wire us_tick = (pre == US_LAST);
  wire gap_en  = links[`RPS_L_END_DIS] & (links[`RPS_L_DIS_TX] | links[`RPS_L_DIS_RX]);
  wire launch  = tx_pend & (~gap_en | (gap_us >= gap));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre       <= 7'h00;
      gap_us    <= 10'h000;
      tx_pend   <= 1'b0;
      tx_air_go <= 1'b0;
    end else begin
      pre       <= (e_end | us_tick) ? 7'h00 : pre + 7'h01;
      gap_us    <= e_end ? 10'h000 : gap_us + {9'h000, us_tick & (gap_us != 10'h3FF)};
      tx_pend   <= (next_state == RPS_TX) & ((state != RPS_TX) | (tx_pend & ~launch));
      tx_air_go <= launch;
    end
  end

  // ----------------------------------------
  // receive field walker
  // ----------------------------------------
  wire [8:0] pay_raw = {1'b0, len_val} + {1'b0, pkt1[`RPS_P1_TAIL_LSB +: 8]};
  wire [8:0] lim     = {1'b0, pkt1[`RPS_P1_LIM_LSB +: 8]};
  wire [8:0] pay_b   = (pay_raw > lim) ? lim : pay_raw;

  always_comb begin
    case (fld)
      2'h0:    fsz = pkt0[`RPS_P0_H0] ? 12'h008 : 12'h000;
      2'h1:    fsz = {8'h00, pkt0[`RPS_P0_LF_LSB +: `RPS_P0_FW]};
      2'h2:    fsz = {8'h00, pkt0[`RPS_P0_H1_LSB +: `RPS_P0_FW]};
      default: fsz = {pay_b, 3'h0};
    endcase
  end

  wire       take   = rx_act & air_in.bit_vld & (fsz != 12'h000);
  wire       f_last = take & (fbits + 12'h001 == fsz);
  wire       skip   = rx_act & (fsz == 12'h000) & (fld != 2'h3);
  wire       byte_d = take & ((bcnt == 3'h7) | f_last);
  wire [7:0] sh_n   = {air_in.bit_val, sh[7:1]};
  wire [7:0] byte_v = sh_n >> (3'h7 - bcnt);
  wire       pa_go  = take & (fld == 2'h3) & (fbits < `RPS_ADDR_BITS);
  wire [47:0] pa_n  = pa_go ? {air_in.bit_val, pa[47:1]} : pa;
  assign pkt_done   = rx_act & (fld == 2'h3) & ((fsz == 12'h000) | f_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_act   <= 1'b0;
      pre_seen <= 1'b0;
    end else begin
      rx_act   <= (next_state == RPS_RX) & ~pkt_done & (rx_act | e_addr);
      pre_seen <= (next_state == RPS_RX) & ~e_addr & (pre_seen | air_in.preamble);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fld <= 2'h0; fbits <= 12'h000; bcnt <= 3'h0; sh <= 8'h00;
      woff <= 9'h000; len_val <= 8'h00; kind <= 1'b0; pa <= 48'h0;
    end else if (!rx_act) begin
      fld <= 2'h0; fbits <= 12'h000; bcnt <= 3'h0;
      woff <= 9'h000; len_val <= 8'h00; kind <= 1'b0;
    end else begin
      if (skip) fld <= fld + 2'h1;
      if (take) begin
        sh    <= sh_n;
        bcnt  <= byte_d ? 3'h0 : bcnt + 3'h1;
        fbits <= f_last ? 12'h000 : fbits + 12'h001;
        if (f_last && fld != 2'h3) fld <= fld + 2'h1;
      end
      if (byte_d) woff <= woff + 9'h001;
      if (byte_d && fld == 2'h1) len_val <= byte_v;
      if (byte_d && fld == 2'h0) kind <= byte_v[`RPS_KIND_BIT];
      pa <= pa_n;
    end
  end

  // one byte holder is enough: bytes arrive tens of cycles apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_out <= '0;
    end else if (byte_d) begin
      dma_out <= '{req: 1'b1, addr: fptr_act + {23'h0, woff}, data: byte_v};
    end else if (dma_ack) begin
      dma_out.req <= 1'b0;
    end
  end

  // ----------------------------------------
  // device address match
  // ----------------------------------------
  for (genvar i = 0; i < N_ENTRY; i++) begin : g_cmp
    assign ent_hit[i] = mcfg[i] & (mcfg[`RPS_MC_KIND_LSB + i] == kind) &
                        (pa_n == {mhigh[i], mlow[i]});
  end
  wire match_on = ~pkt1[`RPS_P1_BIG];
  wire any_hit  = (|ent_hit) & (fsz >= `RPS_ADDR_BITS);
  wire e_hit    = pkt_done & match_on & any_hit;
  wire e_miss   = pkt_done & match_on & ~any_hit;

  // ----------------------------------------
  // bit counter
  // ----------------------------------------
  wire bc_stop = t_bc_hlt | t_stop | go_dis | e_end | e_disd;
  wire bc_go   = t_bc_go | (links[`RPS_L_ADR_BC] & e_addr);
  wire e_bchit = bc_run & ~bc_stop & air_in.bit_vld &
                 (bc_cnt + 16'h0001 == bct);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_run <= 1'b0;
      bc_cnt <= 16'h0000;
    end else if (bc_stop) begin
      bc_run <= 1'b0;
      bc_cnt <= 16'h0000;
    end else if (bc_go) begin
      bc_run <= 1'b1;
      bc_cnt <= 16'h0000;
    end else if (bc_run && air_in.bit_vld) begin
      bc_cnt <= bc_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // signal strength
  // ----------------------------------------
  wire signed [9:0] s_diff = $signed({1'b0, strength_raw, 2'h0}) - $signed({1'b0, filt});
  wire e_ssd = (ss_tmr == 16'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt   <= 9'h000;
      ss_tmr <= 16'h0000;
      ss_val <= 7'h00;
    end else begin
      if (us_tick) filt <= filt + 9'(s_diff >>> FILT_K);
      ss_tmr <= t_ss_go ? SS_CYC : (ss_tmr == 16'h0000 ? ss_tmr : ss_tmr - 16'h0001);
      if (e_ssd) ss_val <= filt[8:2];
    end
  end

  // ----------------------------------------
  // event flags, set beats clear
  // ----------------------------------------
  assign ev_set = {e_bchit, e_ssd, e_miss, e_hit, e_disd, e_end, e_addr, e_ready};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev <= 8'h00;
    else ev <= (ev & ~ev_clr) | ev_set;
  end

  // ----------------------------------------
  // configuration registers, written straight through
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      links <= 8'h00; fptr <= 32'h0; mode <= 4'h0; pkt0 <= 32'h0;
      pkt1 <= 32'h0; gap <= 10'h000; bct <= 16'h0000; mcfg <= 16'h0000;
    end else if (wr) begin
      if (paddr == `RPS_A_LINKS) links <= pwdata[7:0];
      if (paddr == `RPS_A_FPTR)  fptr  <= pwdata;
      if (paddr == `RPS_A_MODE)  mode  <= pwdata[3:0];
      if (paddr == `RPS_A_PKT0)  pkt0  <= pwdata;
      if (paddr == `RPS_A_PKT1)  pkt1  <= pwdata;
      if (paddr == `RPS_A_GAP)   gap   <= pwdata[9:0];
      if (paddr == `RPS_A_BCT)   bct   <= pwdata[15:0];
      if (paddr == `RPS_A_MCFG)  mcfg  <= pwdata[15:0];
    end
  end

  for (genvar i = 0; i < N_ENTRY; i++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mlow[i]  <= 32'h0;
        mhigh[i] <= 16'h0000;
      end else begin
        if (wr && ml_sel && idx == 3'(i)) mlow[i]  <= pwdata;
        if (wr && mh_sel && idx == 3'(i)) mhigh[i] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // read mux and apb answer, zero wait states
  // ----------------------------------------
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    if (|ev_sel) begin
      rd_data = {31'h0, |(ev & ev_sel)};
    end else if (ml_sel) begin
      rd_data = mlow[idx];
    end else if (mh_sel) begin
      rd_data = {16'h0000, mhigh[idx]};
    end else begin
      case (paddr)
        `RPS_A_GO_TX, `RPS_A_GO_RX, `RPS_A_START, `RPS_A_STOP, `RPS_A_DIS,
        `RPS_A_SS_GO, `RPS_A_BC_GO, `RPS_A_BC_HALT: rd_data = 32'h0;
        `RPS_A_LINKS: rd_data = {24'h0, links};
        `RPS_A_FPTR:  rd_data = fptr;
        `RPS_A_MODE:  rd_data = {28'h0, mode};
        `RPS_A_PKT0:  rd_data = pkt0;
        `RPS_A_PKT1:  rd_data = pkt1;
        `RPS_A_GAP:   rd_data = {22'h0, gap};
        `RPS_A_SSV:   rd_data = {25'h0, ss_val};
        `RPS_A_STATE: rd_data = {28'h0, state};
        `RPS_A_BCT:   rd_data = {16'h0, bct};
        `RPS_A_MCFG:  rd_data = {16'h0, mcfg};
        default:      rd_ok   = 1'b0;
      endcase
    end
  end

  wire setup = psel & ~penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_ok;
      prdata  <= (setup & ~pwrite) ? rd_data : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/rps_sequencer_checker.sv ----
// port-level assertions for the packet sequencer
`timescale 1ns/100ps
`default_nettype none
module rps_sequencer_checker import rps_pkg::*; (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // air and ram
  input wire logic        phy_rx_on,
  input wire logic        phy_tx_on,
  input wire logic [3:0]  phy_mode,
  input wire logic        tx_air_go,
  input wire rps_dma_s    dma_out,
  input wire logic        dma_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ram_req_hold_a: assert property (dma_out.req && !dma_ack |=> dma_out.req && $stable(dma_out.addr) && $stable(dma_out.data))
    else $error("ram request changed before ack");
  ram_req_drop_a: assert property (dma_out.req && dma_ack |=> !dma_out.req)
    else $error("ram request held after ack");
  phy_exclusive_a: assert property (!(phy_rx_on && phy_tx_on))
    else $error("receiver and transmitter both on");
  tx_go_pulse_a: assert property (tx_air_go |-> phy_tx_on ##1 !tx_air_go)
    else $error("tx_air_go outside tx or too long");
  mode_held_a: assert property (phy_rx_on && $past(phy_rx_on) |-> $stable(phy_mode))
    else $error("mode changed while receiving");
endmodule
bind rps_sequencer rps_sequencer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phy_rx_on(phy_rx_on), .phy_tx_on(phy_tx_on), .phy_mode(phy_mode),
  .tx_air_go(tx_air_go), .dma_out(dma_out), .dma_ack(dma_ack));
`default_nettype wire

// ---- sim/rps_air_model.sv ----
// remote radio: sends one frame over the air and accepts ram byte writes
`timescale 1ns/100ps
`default_nettype none
module rps_air_model import rps_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [63:0] frame,
  input  wire rps_dma_s    dma_out,
  output var rps_air_s     air_in,
  output logic             dma_ack,
  output logic             busy
);
  logic [7:0] mem [0:15];
  // bit_val shows the inverse between strobes so a stale level never reads as data
  task automatic strobe(input logic p, input logic a, input logic v, input logic b);
    repeat (20) @(posedge pclk);
    air_in <= '{preamble: p, addr_ok: a, bit_vld: v, bit_val: b, tx_done: 1'b0};
    @(posedge pclk);
    air_in <= '{preamble: 1'b0, addr_ok: 1'b0, bit_vld: 1'b0, bit_val: ~b, tx_done: 1'b0};
  endtask
  initial begin
    air_in = '0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        repeat (3) strobe(1'b0, 1'b0, 1'b1, 1'b1); // noise before preamble
        strobe(1'b1, 1'b0, 1'b0, 1'b0);
        strobe(1'b0, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 64; i++) strobe(1'b0, 1'b0, 1'b1, frame[i]);
        busy <= 1'b0;
      end
    end
  end
  initial begin
    dma_ack = 1'b0;
    forever begin
      @(posedge pclk);
      if (dma_out.req === 1'b1) begin
        repeat (slow ? 7 : 0) @(posedge pclk);
        mem[dma_out.addr[3:0]] <= dma_out.data;
        dma_ack <= 1'b1;
        @(posedge pclk);
        dma_ack <= 1'b0;
        @(posedge pclk);
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_radio_packet_sequencer.sv ----
// self-checking bench for the packet sequencer
`timescale 1ns/100ps
`default_nettype none
`include "rps_map.svh"
module tb_radio_packet_sequencer import rps_pkg::*;;
  localparam logic [63:0] F1 = {48'h0C0B0A030201, 8'h06, 8'h40};
  localparam logic [63:0] F2 = {48'h0C0D0A030201, 8'h09, 8'h40};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic phy_rx_on, phy_tx_on, tx_air_go, dma_ack, air_go, slow, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic [6:0]  strength_raw;
  logic [3:0]  phy_mode;
  logic [63:0] frame;
  rps_air_s    air_in;
  rps_dma_s    dma_out;
  int          err_count, checks, cyc, t0;
  logic        tx_seen = 1'b0;
  always #5 pclk = ~pclk;
  // tx_air_go stands one cycle only, so keep a sticky copy for the checks
  always @(posedge pclk) if (tx_air_go === 1'b1) tx_seen <= 1'b1;
  rps_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .air_in(air_in), .strength_raw(strength_raw), .phy_rx_on(phy_rx_on),
    .phy_tx_on(phy_tx_on), .phy_mode(phy_mode), .tx_air_go(tx_air_go), .dma_out(dma_out),
    .dma_ack(dma_ack));
  rps_air_model u_air (.pclk(pclk), .go(air_go), .slow(slow), .frame(frame), .dma_out(dma_out),
    .air_in(air_in), .dma_ack(dma_ack), .busy(busy));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_val);
  endtask
  task automatic send(input logic [63:0] f, input logic s);
    frame <= f;
    slow <= s;
    air_go <= 1'b1;
    @(posedge pclk);
    air_go <= 1'b0;
    repeat (2) @(posedge pclk);
    while (busy) begin
      @(posedge pclk);
    end
    repeat (60) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, air_go, slow} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    frame = 64'h0;
    strength_raw = 7'h50;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RPS_A_STATE, 32'h0, "state after reset");
    apb(1'b0, 12'h7FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rd_err});
    apb(1'b1, `RPS_A_GAP, 32'hFFFF_FFFF);
    rd(`RPS_A_GAP, 32'h3FF, "gap");
    apb(1'b1, `RPS_A_PKT0, 32'h108);
    apb(1'b1, `RPS_A_PKT1, 32'h6);
    apb(1'b1, `RPS_A_MLOW, 32'h0A030201);
    apb(1'b1, `RPS_A_MHIGH, 32'h0C0B);
    apb(1'b1, `RPS_A_MCFG, 32'h101);
    apb(1'b1, `RPS_A_LINKS, 32'h40);
    apb(1'b1, `RPS_A_FPTR, 32'h20);
    apb(1'b1, `RPS_A_BCT, 32'h10);
    apb(1'b1, `RPS_A_MODE, 32'h3);
    apb(1'b1, `RPS_A_GO_RX, 32'h1);
    t0 = cyc;
    apb(1'b1, `RPS_A_START, 32'h1); // start during ramp is ignored
    apb(1'b1, `RPS_A_MODE, 32'h5); // live mode must keep 3
    rd(`RPS_A_STATE, 32'h1, "ramp state");
    do apb(1'b0, `RPS_A_EV_READY, 32'h0); while (rd_val[0] !== 1'b1 && cyc - t0 < 4200);
    chk("ramp time", 32'h1, {31'h0, cyc - t0 >= 3996 && cyc - t0 <= 4012});
    rd(`RPS_A_STATE, 32'h2, "wait state");
    apb(1'b1, `RPS_A_EV_READY, 32'h0);
    rd(`RPS_A_EV_READY, 32'h0, "ready cleared");
    apb(1'b1, `RPS_A_START, 32'h1);
    rd(`RPS_A_STATE, 32'h3, "listen state");
    chk("rx on", 32'h1, {31'h0, phy_rx_on});
    chk("mode copy", 32'h3, {28'h0, phy_mode});
    apb(1'b1, `RPS_A_SS_GO, 32'h1);
    repeat (30) @(posedge pclk);
    rd(`RPS_A_EV_SSD, 32'h1, "strength done");
    apb(1'b0, `RPS_A_SSV, 32'h0);
    chk("strength", 32'h1, {31'h0, rd_val >= 32'h48 && rd_val <= 32'h50});
    send(F1, 1'b0);
    rd(`RPS_A_EV_ADDR, 32'h1, "address");
    rd(`RPS_A_EV_END, 32'h1, "end");
    rd(`RPS_A_EV_HIT, 32'h1, "hit");
    rd(`RPS_A_EV_MISS, 32'h0, "no miss");
    rd(`RPS_A_EV_BCHIT, 32'h1, "bit count");
    for (int i = 0; i < 8; i++) chk("ram", {24'h0, F1[8*i +: 8]}, {24'h0, u_air.mem[i]});
    rd(`RPS_A_STATE, 32'h2, "back to wait");
    apb(1'b1, `RPS_A_EV_HIT, 32'h0);
    apb(1'b1, `RPS_A_EV_BCHIT, 32'h0);
    apb(1'b1, `RPS_A_FPTR, 32'h28);
    apb(1'b1, `RPS_A_START, 32'h1);
    send(F2, 1'b1);
    rd(`RPS_A_EV_MISS, 32'h1, "miss");
    rd(`RPS_A_EV_HIT, 32'h0, "no hit");
    rd(`RPS_A_EV_BCHIT, 32'h1, "bit count again");
    chk("no tx go", 32'h0, {31'h0, tx_seen});
    chk("kept length", 32'h9, {24'h0, u_air.mem[9]});
    chk("last byte", {24'h0, F2[63:56]}, {24'h0, u_air.mem[15]});
    apb(1'b1, `RPS_A_DIS, 32'h1);
    repeat (250) @(posedge pclk);
    rd(`RPS_A_EV_DISD, 32'h1, "disabled");
    rd(`RPS_A_STATE, 32'h0, "off");
    // ready to start and disabled to tx, but no end to disable: gap not enforced
    apb(1'b1, `RPS_A_LINKS, 32'h5);
    apb(1'b1, `RPS_A_GO_TX, 32'h1);
    repeat (4100) @(posedge pclk);
    rd(`RPS_A_STATE, 32'hB, "tx by shortcut");
    chk("tx mode", 32'h5, {28'h0, phy_mode});
    chk("tx on rx off", 32'h2, {30'h0, phy_tx_on, phy_rx_on});
    chk("tx go", 32'h1, {31'h0, tx_seen});
    finish_test;
  end
endmodule
`default_nettype wire
